// ===== hdl/tifl_params.svh
`ifndef TIFL_PARAMS_SVH
`define TIFL_PARAMS_SVH

// Counter and compare width.
`define TIFL_CNT_W 16
// Default channel count.
`define TIFL_NUM_CH 2
// Counter terminal value when free-running.
`define TIFL_CNT_MAX 16'hffff
// Counter zero value.
`define TIFL_CNT_ZERO 16'h0000
// Reset value of every flag, the run bit and the overflow enable.
`define TIFL_FLAG_RST 1'b0
// Edge select codes (high bit, low bit).
`define TIFL_EDGE_NONE 2'h0
`define TIFL_EDGE_RISE 2'h1
`define TIFL_EDGE_FALL 2'h2
`define TIFL_EDGE_BOTH 2'h3

`endif

// ===== hdl/tifl_pkg.sv
package tifl_pkg;
   // Channel modes as seen by the flag logic.
   typedef enum logic [1:0] {
      TIFL_MODE_CAPTURE = 2'h0,
      TIFL_MODE_COMPARE = 2'h1,
      TIFL_MODE_EPWM = 2'h2,
      TIFL_MODE_EPWM_B = 2'h3
   } tifl_mode_type;
   // States of the two-step clear sequence.
   typedef enum logic [1:0] {
      TIFL_CLR_IDLE = 2'b01,
      TIFL_CLR_ARMED = 2'b10
   } tifl_clr_type;
endpackage

// ===== hdl/tifl_flag_cell.sv
`timescale 1ns/100ps
`default_nettype none
`include "tifl_params.svh"
module tifl_flag_cell
   import tifl_pkg::*;
(
   input wire logic i_core_clk, // Counter clock.
   input wire logic i_reset, // Asynchronous reset, active high.
   input wire logic i_set, // Set condition pulse.
   input wire logic i_rd, // Software reads the flag.
   input wire logic i_wr, // Software writes the flag bit.
   input wire logic i_wr_data, // Value written.
   input wire logic i_enable, // Local interrupt enable.
   output logic o_flag, // Flag state.
   output logic o_irq // Interrupt request, active high.
);
   logic flag_ff;
   logic nxt_flag;
   tifl_clr_type clr_ff;
   tifl_clr_type nxt_clr;

   // Flag and clear-sequence next state; a set always wins and restarts the sequence from idle.
   always_comb begin
      nxt_flag = flag_ff;
      nxt_clr = clr_ff;
      case (clr_ff)
         TIFL_CLR_IDLE: begin
            if (i_rd && flag_ff) begin
               nxt_clr = TIFL_CLR_ARMED;
            end
         end
         TIFL_CLR_ARMED: begin
            if (i_wr && !i_wr_data) begin
               nxt_flag = 1'b0;
               nxt_clr = TIFL_CLR_IDLE;
            end
         end
         default: begin
            nxt_clr = TIFL_CLR_IDLE;
         end
      endcase
      if (i_set) begin
         nxt_flag = 1'b1;
         nxt_clr = TIFL_CLR_IDLE;
      end
      // Writing one or writing zero without an armed read leaves the flag alone.
      if (i_wr && i_wr_data && !i_set) begin
         nxt_flag = flag_ff;
      end
   end

   // Flag registers.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         flag_ff <= `TIFL_FLAG_RST;
         clr_ff <= TIFL_CLR_IDLE;
      end else begin
         flag_ff <= nxt_flag;
         clr_ff <= nxt_clr;
      end
   end

   // Request follows flag and enable.
   assign o_flag = flag_ff;
   assign o_irq = flag_ff & i_enable;
endmodule
`default_nettype wire

// ===== hdl/tifl_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "tifl_params.svh"
module tifl_counter
   import tifl_pkg::*;
#(
   parameter int CNT_W = `TIFL_CNT_W
) (
   input wire logic i_core_clk, // Counter clock.
   input wire logic i_reset, // Asynchronous reset, active high.
   input wire logic i_run, // Counter clock enable from control.
   input wire logic i_center_align_select, // Up/down counting.
   input wire logic [CNT_W-1:0] i_modulo, // Modulo; zero means free-running.
   output logic [CNT_W-1:0] o_count, // Counter value.
   output logic o_down, // Counting down.
   output logic o_tick, // Counter advances this cycle.
   output logic o_overflow // Overflow event pulse.
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic down_ff;
   logic nxt_down;
   logic [CNT_W-1:0] top;

   // Counter next state and overflow detection.
   always_comb begin
      top = (i_modulo == '0) ? CNT_W'(`TIFL_CNT_MAX) : i_modulo;
      nxt_cnt = cnt_ff;
      nxt_down = down_ff;
      o_overflow = 1'b0;
      if (i_run) begin
         if (!i_center_align_select) begin
            nxt_down = 1'b0;
            if (cnt_ff == top) begin
               nxt_cnt = '0;
               o_overflow = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end else if (!down_ff) begin
            if (cnt_ff >= top) begin
               nxt_down = 1'b1;
               nxt_cnt = cnt_ff - 1'b1;
               o_overflow = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end else begin
            if (cnt_ff == '0) begin
               nxt_down = 1'b0;
               nxt_cnt = cnt_ff + 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
      end
   end

   // Counter registers.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_ff <= CNT_W'(`TIFL_CNT_ZERO);
         down_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         down_ff <= nxt_down;
      end
   end

   assign o_count = cnt_ff;
   assign o_down = down_ff;
   assign o_tick = i_run;
endmodule
`default_nettype wire

// ===== hdl/tifl_top.sv
// Summary of operation
// - One overflow interrupt source plus one per channel are provided.
// - Without center align, a capture channel sets its flag on each selected pin edge.
// - A compare channel sets its flag when the counter equals its 16-bit value.
// - Flags set on their condition whatever the enable bits hold.
// - Each request is high while its enable and flag are both set.
// - All requests are active high.
// - A flag clears only on a read while set followed by a zero write.
// - An event between the read and the write restarts the sequence and keeps the flag.
// - Without center align, overflow sets at modulo to zero, or 0xffff to zero free-running.
// - With center align, overflow sets when counting turns from up to down at modulo.
// - Two edge-select bits choose none, rising, falling or both edges for capture.
// - Edge-aligned PWM sets the flag on the match that ends the duty portion.
// - Center-aligned PWM sets the flag on both matches of each cycle.
// - Center align makes the counter count up to modulo then down to zero.
// - Reset clears control, stopping the counter and clearing the overflow enable.
`timescale 1ns/100ps
`default_nettype none
`include "tifl_params.svh"
module tifl_top
   import tifl_pkg::*;
#(
   parameter int NUM_CH = `TIFL_NUM_CH,
   parameter int CNT_W = `TIFL_CNT_W
) (
   input wire logic i_core_clk, // Counter clock, 50 MHz.
   input wire logic i_reset, // Asynchronous reset, active high.
   input wire logic i_counter_run, // Counter clock select, nonzero runs.
   input wire logic i_overflow_irq_enable, // Overflow interrupt enable.
   input wire logic i_center_align_select, // Up/down counting select.
   input wire logic [CNT_W-1:0] i_modulo, // Modulo value.
   input wire logic i_ovf_rd, // Software reads the overflow flag.
   input wire logic i_ovf_wr, // Software writes the overflow flag.
   input wire logic i_ovf_wr_data, // Value written to the overflow flag.
   input wire logic [NUM_CH-1:0] i_mode_sel_high, // Channel mode select high bits.
   input wire logic [NUM_CH-1:0] i_mode_sel_low, // Channel mode select low bits.
   input wire logic [NUM_CH-1:0] i_edge_select_high, // Edge select high bits.
   input wire logic [NUM_CH-1:0] i_edge_select_low, // Edge select low bits.
   input wire logic [NUM_CH-1:0] i_channel_irq_enable, // Channel interrupt enables.
   input wire logic [NUM_CH*CNT_W-1:0] i_ch_value, // Channel values, packed.
   input wire logic [NUM_CH-1:0] i_ch_pin, // Channel input pins.
   input wire logic [NUM_CH-1:0] i_ch_rd, // Software reads channel flags.
   input wire logic [NUM_CH-1:0] i_ch_wr, // Software writes channel flags.
   input wire logic [NUM_CH-1:0] i_ch_wr_data, // Values written to channel flags.
   output logic [CNT_W-1:0] o_count, // Counter value.
   output logic [NUM_CH*CNT_W-1:0] o_capture, // Captured counts, packed.
   output logic o_counter_overflow_flag, // Overflow flag.
   output logic o_overflow_irq, // Overflow request, active high.
   output logic [NUM_CH-1:0] o_channel_event_flag, // Channel flags.
   output logic [NUM_CH-1:0] o_channel_irq // Channel requests, active high.
);
   logic [NUM_CH-1:0] pin_ff;
   logic [NUM_CH-1:0] nxt_pin;
   logic [CNT_W-1:0] cap_ff [NUM_CH];
   logic [CNT_W-1:0] nxt_cap [NUM_CH];
   logic [NUM_CH-1:0] ch_set;
   logic run_ff;
   logic nxt_run;
   logic ovf_enable_ff;
   logic nxt_ovf_enable;
   logic tick;
   logic overflow;

   // Decodes the channel mode from the high and low mode select bits.
   function automatic tifl_mode_type mode_of(input logic msb, input logic msa);
      if (msb) begin
         mode_of = TIFL_MODE_EPWM;
      end else if (msa) begin
         mode_of = TIFL_MODE_COMPARE;
      end else begin
         mode_of = TIFL_MODE_CAPTURE;
      end
   endfunction

   // Detects the selected capture edge.
   function automatic logic edge_hit(input logic [1:0] sel, input logic old_v, input logic new_v);
      case (sel)
         `TIFL_EDGE_RISE: edge_hit = !old_v && new_v;
         `TIFL_EDGE_FALL: edge_hit = old_v && !new_v;
         `TIFL_EDGE_BOTH: edge_hit = old_v != new_v;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   // Control bits are held in registers so reset stops the counter and clears the enable.
   always_comb begin
      nxt_run = i_counter_run;
      nxt_ovf_enable = i_overflow_irq_enable;
   end

   // Control registers.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         run_ff <= `TIFL_FLAG_RST;
         ovf_enable_ff <= `TIFL_FLAG_RST;
      end else begin
         run_ff <= nxt_run;
         ovf_enable_ff <= nxt_ovf_enable;
      end
   end

   // Main counter.
   tifl_counter #(
      .CNT_W(CNT_W)
   ) u_counter (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_run(run_ff),
      .i_center_align_select(i_center_align_select),
      .i_modulo(i_modulo),
      .o_count(o_count),
      .o_down(),
      .o_tick(tick),
      .o_overflow(overflow)
   );

   // Overflow flag, separate from all channel flags.
   tifl_flag_cell u_ovf_flag (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_set(overflow),
      .i_rd(i_ovf_rd),
      .i_wr(i_ovf_wr),
      .i_wr_data(i_ovf_wr_data),
      .i_enable(ovf_enable_ff),
      .o_flag(o_counter_overflow_flag),
      .o_irq(o_overflow_irq)
   );

   // Channel set conditions and capture next values.
   always_comb begin
      nxt_pin = i_ch_pin;
      for (int c = 0; c < NUM_CH; c++) begin
         logic [CNT_W-1:0] val;
         logic match;
         val = i_ch_value[c*CNT_W +: CNT_W];
         match = tick && (o_count == val);
         nxt_cap[c] = cap_ff[c];
         ch_set[c] = 1'b0;
         if (i_center_align_select) begin
            ch_set[c] = match;
         end else begin
            case (mode_of(i_mode_sel_high[c], i_mode_sel_low[c]))
               TIFL_MODE_CAPTURE: begin
                  if (edge_hit({i_edge_select_high[c], i_edge_select_low[c]},
                               pin_ff[c], i_ch_pin[c])) begin
                     ch_set[c] = 1'b1;
                     nxt_cap[c] = o_count;
                  end
               end
               TIFL_MODE_COMPARE: ch_set[c] = match;
               TIFL_MODE_EPWM: ch_set[c] = match;
               default: ch_set[c] = match;
            endcase
         end
      end
   end

   // Pin history and captured counts.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_ff <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            cap_ff[c] <= '0;
         end
      end else begin
         pin_ff <= nxt_pin;
         for (int c = 0; c < NUM_CH; c++) begin
            cap_ff[c] <= nxt_cap[c];
         end
      end
   end

   // Capture outputs.
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         o_capture[c*CNT_W +: CNT_W] = cap_ff[c];
      end
   end

   // One independent flag cell per channel.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      tifl_flag_cell u_ch_flag (
         .i_core_clk(i_core_clk),
         .i_reset(i_reset),
         .i_set(ch_set[g]),
         .i_rd(i_ch_rd[g]),
         .i_wr(i_ch_wr[g]),
         .i_wr_data(i_ch_wr_data[g]),
         .i_enable(i_channel_irq_enable[g]),
         .o_flag(o_channel_event_flag[g]),
         .o_irq(o_channel_irq[g])
      );
   end
endmodule
`default_nettype wire

// ===== testbench/tifl_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tifl_top_asserts #(
   parameter int NUM_CH = 2,
   parameter int CNT_W = 16
) (
   input wire logic i_core_clk, // Clock.
   input wire logic i_reset, // Reset.
   input wire logic i_counter_run, // Run.
   input wire logic i_overflow_irq_enable, // Overflow enable.
   input wire logic i_center_align_select, // Up/down.
   input wire logic [CNT_W-1:0] i_modulo, // Modulo.
   input wire logic i_ovf_wr, // Write strobe.
   input wire logic i_ovf_wr_data, // Write data.
   input wire logic [NUM_CH-1:0] i_mode_sel_high, // Mode high.
   input wire logic [NUM_CH-1:0] i_mode_sel_low, // Mode low.
   input wire logic [NUM_CH-1:0] i_edge_select_high, // Edge high.
   input wire logic [NUM_CH-1:0] i_edge_select_low, // Edge low.
   input wire logic [NUM_CH-1:0] i_channel_irq_enable, // Enables.
   input wire logic [NUM_CH*CNT_W-1:0] i_ch_value, // Values.
   input wire logic [NUM_CH-1:0] i_ch_pin, // Pins.
   input wire logic [CNT_W-1:0] o_count, // Counter.
   input wire logic o_counter_overflow_flag, // Overflow flag.
   input wire logic o_overflow_irq, // Overflow request.
   input wire logic [NUM_CH-1:0] o_channel_event_flag, // Flags.
   input wire logic [NUM_CH-1:0] o_channel_irq // Requests.
);
   // Terminal count of the up-only counter; zero modulo means free-running.
   logic [CNT_W-1:0] top;
   assign top = (i_modulo == '0) ? '1 : i_modulo;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // Requests follow their flags and enables.
   a_ovf_irq_and: assert property (
      o_overflow_irq == (o_counter_overflow_flag && $past(i_overflow_irq_enable)))
      else $error("Overflow request wrong.");
   a_ch_irq_and: assert property (
      o_channel_irq == (o_channel_event_flag & i_channel_irq_enable))
      else $error("Channel request wrong.");
   // A flag only falls after a zero write.
   a_ovf_clear_seq: assert property (
      $fell(o_counter_overflow_flag) |-> $past(i_ovf_wr) && !$past(i_ovf_wr_data))
      else $error("Overflow flag fell without zero write.");
   // Overflow events in both counting modes.
   a_ovf_wrap_set: assert property (
      !i_center_align_select && o_count == top ##1 o_count == '0 |-> o_counter_overflow_flag)
      else $error("Overflow flag missing at wrap.");
   a_ovf_turn_set: assert property (
      i_center_align_select && o_count == i_modulo - 1'b1 ##1 o_count == i_modulo
      |=> o_counter_overflow_flag) else $error("Overflow flag missing at turn.");
   // Counter matches on a non-capture channel.
   a_match_set: assert property (
      $past(i_counter_run) && (i_mode_sel_high[0] || i_mode_sel_low[0])
      && o_count == i_ch_value[CNT_W-1:0] |=> o_channel_event_flag[0])
      else $error("Match flag missing.");
   // Capture edges on channel one.
   a_cap_rise_set: assert property (
      !i_center_align_select && !i_mode_sel_high[1] && !i_mode_sel_low[1] && i_edge_select_low[1]
      && $rose(i_ch_pin[1]) |-> ##[1:3] o_channel_event_flag[1])
      else $error("Rising capture flag missing.");
   a_cap_fall_set: assert property (
      !i_center_align_select && !i_mode_sel_high[1] && !i_mode_sel_low[1] && i_edge_select_high[1]
      && $fell(i_ch_pin[1]) |-> ##[1:3] o_channel_event_flag[1])
      else $error("Falling capture flag missing.");
   // Main scenarios reached.
   c_ovf_irq: cover property (o_overflow_irq);
   c_ch_irq: cover property (|o_channel_irq);
   c_ovf_clear: cover property ($fell(o_counter_overflow_flag));
endmodule
bind tifl_top tifl_top_asserts #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) tifl_top_asserts_i (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_counter_run(i_counter_run),
   .i_overflow_irq_enable(i_overflow_irq_enable), .i_modulo(i_modulo),
   .i_center_align_select(i_center_align_select), .i_ovf_wr(i_ovf_wr),
   .i_ovf_wr_data(i_ovf_wr_data), .i_mode_sel_high(i_mode_sel_high),
   .i_mode_sel_low(i_mode_sel_low), .i_edge_select_high(i_edge_select_high),
   .i_edge_select_low(i_edge_select_low), .i_channel_irq_enable(i_channel_irq_enable),
   .i_ch_value(i_ch_value), .i_ch_pin(i_ch_pin), .o_count(o_count),
   .o_counter_overflow_flag(o_counter_overflow_flag), .o_overflow_irq(o_overflow_irq),
   .o_channel_event_flag(o_channel_event_flag), .o_channel_irq(o_channel_irq));
`default_nettype wire

// ===== testbench/tifl_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module tifl_top_test;
   // Short names for the ports of the flag logic.
   logic clk, rst, run, oen, cas, ord, owr, owd, ofl, oirq;
   logic [15:0] mdl, cnt;
   logic [1:0] msh, msl, esh, esl, cen, pin, crd, cwr, cwd, cfl, cirq;
   logic [31:0] chv, cap;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   tifl_top tifl_top_i (
      .i_core_clk(clk), .i_reset(rst), .i_counter_run(run),
      .i_overflow_irq_enable(oen), .i_center_align_select(cas), .i_modulo(mdl),
      .i_ovf_rd(ord), .i_ovf_wr(owr), .i_ovf_wr_data(owd), .i_mode_sel_high(msh),
      .i_mode_sel_low(msl), .i_edge_select_high(esh), .i_edge_select_low(esl),
      .i_channel_irq_enable(cen), .i_ch_value(chv), .i_ch_pin(pin), .i_ch_rd(crd),
      .i_ch_wr(cwr), .i_ch_wr_data(cwd), .o_count(cnt), .o_capture(cap),
      .o_counter_overflow_flag(ofl), .o_overflow_irq(oirq),
      .o_channel_event_flag(cfl), .o_channel_irq(cirq));
   // Clock at 50 MHz.
   always #10 clk = ~clk;
   // Cut a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One software access to a flag: k of 2 means the overflow flag.
   task automatic sw(input int k, input logic r, input logic w, input logic d);
      @(posedge clk);
      if (k == 2) begin
         ord <= r;
         owr <= w;
         owd <= d;
      end else begin
         crd[k] <= r;
         cwr[k] <= w;
         cwd[k] <= d;
      end
      @(posedge clk);
      ord <= 1'h0;
      owr <= 1'h0;
      crd <= 2'h0;
      cwr <= 2'h0;
      #1;
   endtask
   // Read while set, then write zero.
   task automatic clr(input int k);
      sw(k, 1'h1, 1'h0, 1'h0);
      sw(k, 1'h0, 1'h1, 1'h0);
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      int k;
      k = 0;
      while (cnt !== v && k < 300) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(cnt, v);
   endtask
   task automatic rst_t(input int n);
      @(posedge clk);
      rst <= 1'h1;
      repeat (n) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      #1;
      chk(cnt, 16'h0);
      chk({ofl, oirq, cfl, cirq}, 16'h0);
      $display("reset test ended");
   endtask
   // Overflow flag: set, refused clears, restarted and completed clear.
   task automatic t_ovf();
      @(posedge clk);
      mdl <= 16'h000f;
      oen <= 1'h1;
      run <= 1'h1;
      #1;
      wait_cnt(16'h000f);
      @(posedge clk);
      run <= 1'h0;
      #1;
      chk(ofl, 1'h1);
      chk(oirq, 1'h1);
      sw(2, 1'h0, 1'h1, 1'h0);
      chk(ofl, 1'h1);
      sw(2, 1'h1, 1'h0, 1'h0);
      sw(2, 1'h0, 1'h1, 1'h1);
      chk(ofl, 1'h1);
      sw(2, 1'h1, 1'h0, 1'h0);
      @(posedge clk);
      run <= 1'h1;
      #1;
      wait_cnt(16'h000f);
      @(posedge clk);
      run <= 1'h0;
      sw(2, 1'h0, 1'h1, 1'h0);
      chk(ofl, 1'h1);
      clr(2);
      chk({ofl, oirq}, 16'h0);
      $display("overflow test ended");
   endtask
   // Compare match on channel zero and edge-aligned match on channel one, masked, then channel zero enabled.
   task automatic t_cmp();
      @(posedge clk);
      msl <= 2'h1;
      msh <= 2'h2;
      chv <= 32'h0005_0007;
      run <= 1'h1;
      #1;
      wait_cnt(16'h0007);
      @(posedge clk);
      run <= 1'h0;
      #1;
      chk(cfl, 2'h3);
      chk(cirq, 2'h0);
      @(posedge clk);
      cen <= 2'h1;
      #1;
      chk({oirq, cirq}, 16'h1);
      clr(0);
      chk(cfl, 2'h2);
      clr(1);
      chk(cfl, 2'h0);
      // Channel one goes back to capture for the next test.
      @(posedge clk);
      msh <= 2'h0;
      $display("compare test ended");
   endtask
   // Every edge code on channel one, rising then falling pin.
   task automatic t_cap();
      logic [1:0] e;
      for (int i = 0; i < 4; i++) begin
         e = 2'(i);
         @(posedge clk);
         esh[1] <= e[1];
         esl[1] <= e[0];
         @(posedge clk);
         pin[1] <= 1'h1;
         repeat (4) @(posedge clk);
         #1;
         chk(cfl[1], e[0]);
         clr(1);
         @(posedge clk);
         pin[1] <= 1'h0;
         repeat (4) @(posedge clk);
         #1;
         chk(cfl[1], e[1]);
         clr(1);
      end
      // Run is registered, so the compare test left the counter two counts past 7.
      chk(cap[31:16], 16'h0009);
      chk(cap[15:0], 16'h0000);
      $display("capture test ended");
   endtask
   // Up/down counting with a centre-aligned channel.
   task automatic t_ctr();
      logic [15:0] mx, pv;
      logic dn;
      mx = 16'h0;
      pv = 16'h0;
      dn = 1'h0;
      @(posedge clk);
      cas <= 1'h1;
      mdl <= 16'h0006;
      msh <= 2'h1;
      msl <= 2'h0;
      chv <= 32'h0000_0003;
      run <= 1'h1;
      repeat (30) begin
         @(posedge clk);
         #1;
         if (cnt > mx) mx = cnt;
         if (cnt < pv) dn = 1'h1;
         pv = cnt;
      end
      chk(mx, 16'h0006);
      chk({dn, ofl, cfl[0]}, 16'h7);
      @(posedge clk);
      run <= 1'h0;
      $display("centre test ended");
   endtask
   initial begin
      {clk, run, oen, cas, ord, owr, owd} = 7'h0;
      {msh, msl, esh, esl, cen, pin, crd, cwr, cwd} = 18'h0;
      mdl = 16'h0;
      chv = 32'h0;
      rst = 1'h1;
      rst_t(12);
      t_ovf();
      t_cmp();
      t_cap();
      rst_t(3);
      t_ctr();
      test_done();
   end
endmodule
`default_nettype wire
